/* design/shift_multiply_sequencer.sv */
// Purpose: execution sequences for single shift, pair shift and multiply
// Assumes: general register read port is combinational
// Notes: one register write per cycle, registered
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module shift_multiply_sequencer #(
	parameter int ADDR_W = seq_pkg::APB_ADDR_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                start,
	input  wire seq_pkg::dispatch_t  dispatch,
	output logic      [2:0]          gr_rd_addr,
	input  wire logic [15:0]         gr_rd_data,
	output seq_pkg::gr_write_t       gr_write,
	output seq_pkg::cc_t             cc,
	output logic                     cc_load,
	input  wire logic                break_request,
	output logic                     seq_busy,
	output logic                     seq_done,
	output logic                     fetch_begun,
	output logic                     break_entry
);
	import seq_pkg::*;

	state_t            state_q;
	state_t            state_d;
	op_t               op_q;
	logic [2:0]        src_num_q;
	logic [2:0]        dst_num_q;
	logic [15:0]       operand_buffer_reg_q;
	logic [15:0]       operand_buffer_reg_d;
	logic [15:0]       dest_work_reg_q;
	logic [15:0]       dest_work_reg_d;
	logic [15:0]       source_work_reg_q;
	logic [15:0]       source_work_reg_d;
	logic [STEP_W-1:0] step_counter_q;
	logic [STEP_W-1:0] step_counter_d;
	cc_t               cc_q;
	cc_t               cc_d;
	logic              cc_load_q;
	logic              cc_load_d;
	gr_write_t         gr_write_q;
	gr_write_t         gr_write_d;
	logic              done_q;
	logic              done_d;
	logic              begun_q;
	logic              begun_d;
	logic              brk_entry_q;
	logic              brk_entry_d;
	logic              break_request_sample_q;
	logic              shifted_q;
	logic              shifted_d;
	logic              enable_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;
	logic              accept;
	logic              is_pair;
	logic [15:0]       shift_hi;
	logic [15:0]       shift_lo;
	logic              shift_out;
	logic              shift_v;
	logic [16:0]       mul_add;
	logic [16:0]       mul_sum;
	logic [16:0]       mul_fix;

	assign accept      = start && enable_q && (state_q == S_IDLE);
	assign is_pair     = (op_q == OP_PAIR);
	// second word register: destination number or one
	assign gr_rd_addr  = dst_num_q | 3'h1;
	assign pready      = 1'b1;
	assign prdata      = prdata_q;
	assign pslverr     = pslverr_q;
	assign gr_write    = gr_write_q;
	assign cc          = cc_q;
	assign cc_load     = cc_load_q;
	assign seq_busy    = (state_q != S_IDLE);
	assign seq_done    = done_q;
	assign fetch_begun = begun_q;
	assign break_entry = brk_entry_q;

	// apb slave: zero wait states, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_q  <= CTRL_EN_RST;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
			if (paddr == ADDR_W'(CTRL_OFF))
			begin
				prdata_q[0] <= enable_q;
			end
			else if (paddr == ADDR_W'(STATUS_OFF))
			begin
				prdata_q[ST_STATE_LSB +: 4]    <= state_q;
				prdata_q[ST_BUSY_BIT]          <= seq_busy;
				prdata_q[ST_CC_LSB +: 4]       <= cc_q;
				prdata_q[ST_SC_LSB +: STEP_W]  <= step_counter_q;
			end
			else
			begin
				pslverr_q <= 1'b1;
			end
		end
		else if (psel && penable && pwrite && paddr == ADDR_W'(CTRL_OFF))
		begin
			// disabling only blocks new dispatches, never a running one
			enable_q <= pwdata[0];
		end
	end

	// shifter: positive count toward msb
	always_comb
	begin
		shift_hi  = source_work_reg_q;
		shift_lo  = dest_work_reg_q;
		shift_out = 1'b0;
		shift_v   = 1'b0;
		if (state_q == S_LEFT)
		begin
			shift_hi  = {source_work_reg_q[14:0], is_pair ? dest_work_reg_q[15] : 1'b0};
			shift_lo  = {dest_work_reg_q[14:0], 1'b0};
			shift_out = source_work_reg_q[15];
			shift_v   = source_work_reg_q[15] ^ source_work_reg_q[14];
		end
		else
		begin
			shift_hi  = {source_work_reg_q[15], source_work_reg_q[15:1]};
			shift_lo  = {source_work_reg_q[0], dest_work_reg_q[15:1]};
			shift_out = is_pair ? dest_work_reg_q[0] : source_work_reg_q[0];
		end
	end

	// multiply adder, sign-extended multiplier
	always_comb
	begin
		mul_add = dest_work_reg_q[0] ? {source_work_reg_q[15], source_work_reg_q} : 17'h00000;
		mul_sum = {operand_buffer_reg_q[15], operand_buffer_reg_q} + mul_add;
		mul_fix = {operand_buffer_reg_q[15], operand_buffer_reg_q} - mul_add;
	end

	// sequencing and datapath next values
	always_comb
	begin
		state_d              = state_q;
		operand_buffer_reg_d = operand_buffer_reg_q;
		dest_work_reg_d      = dest_work_reg_q;
		source_work_reg_d    = source_work_reg_q;
		step_counter_d       = step_counter_q;
		cc_d                 = cc_q;
		cc_load_d            = 1'b0;
		gr_write_d           = '0;
		done_d               = 1'b0;
		begun_d              = 1'b0;
		brk_entry_d          = 1'b0;
		shifted_d            = shifted_q;
		unique case (state_q)
			S_IDLE:
			begin
				if (accept)
				begin
					operand_buffer_reg_d = dispatch.dst_data;
					source_work_reg_d    = dispatch.src_data;
					shifted_d            = 1'b0;
					if (dispatch.op == OP_MUL)
						state_d = S_MUL_SETUP;
					else if (dispatch.op != 2'b11)
						state_d = S_ASH_LOAD;
				end
			end
			S_ASH_LOAD:
			begin
				dest_work_reg_d = operand_buffer_reg_q;
				state_d         = S_ASH_COUNT;
			end
			S_ASH_COUNT:
			begin
				step_counter_d = dest_work_reg_q[STEP_W-1:0];
				if (is_pair)
					dest_work_reg_d = gr_rd_data;
				state_d = S_ASH_TEST;
			end
			S_ASH_TEST:
			begin
				cc_d      = '{n: source_work_reg_q[15], z: (source_work_reg_q == 16'h0000), v: 1'b0, c: 1'b0};
				cc_load_d = 1'b1;
				if (step_counter_q == '0)
				begin
					if (is_pair)
						state_d = S_PAIR_END;
					else
					begin
						done_d  = 1'b1;
						state_d = S_IDLE;
					end
				end
				else if (step_counter_q[STEP_W-1])
				begin
					step_counter_d = step_counter_q + 1'b1;
					state_d        = S_RIGHT;
				end
				else
				begin
					step_counter_d = step_counter_q - 1'b1;
					state_d        = S_LEFT;
				end
			end
			S_LEFT, S_RIGHT:
			begin
				source_work_reg_d = shift_hi;
				if (is_pair)
					dest_work_reg_d = shift_lo;
				cc_d      = '{n: shift_hi[15], z: (shift_hi == 16'h0000), v: shift_v, c: shift_out};
				cc_load_d = 1'b1;
				if (state_q == S_LEFT)
					step_counter_d = step_counter_q - 1'b1;
				else
					step_counter_d = step_counter_q + 1'b1;
				if (step_counter_q == '0)
				begin
					step_counter_d = '1;
					shifted_d      = 1'b1;
					gr_write_d     = '{we: 1'b1, addr: src_num_q, data: shift_hi};
					if (is_pair)
						state_d = S_PAIR_END;
					else
					begin
						done_d  = 1'b1;
						state_d = S_IDLE;
					end
				end
			end
			S_PAIR_END:
			begin
				cc_d.n    = source_work_reg_q[15];
				cc_d.z    = (source_work_reg_q == 16'h0000) && (dest_work_reg_q == 16'h0000);
				cc_load_d = 1'b1;
				if (shifted_q)
					gr_write_d = '{we: 1'b1, addr: dst_num_q | 3'h1, data: dest_work_reg_q};
				done_d      = 1'b1;
				begun_d     = 1'b1;
				brk_entry_d = break_request;
				state_d     = S_IDLE;
			end
			S_MUL_SETUP:
			begin
				dest_work_reg_d = operand_buffer_reg_q;
				step_counter_d  = SC_MUL_INIT;
				state_d         = S_MUL_CLEAR;
			end
			S_MUL_CLEAR:
			begin
				operand_buffer_reg_d = 16'h0000;
				step_counter_d       = step_counter_q - 1'b1;
				state_d              = S_MUL_STEP;
			end
			S_MUL_STEP:
			begin
				operand_buffer_reg_d = mul_sum[16:1];
				dest_work_reg_d      = {mul_sum[0], dest_work_reg_q[15:1]};
				step_counter_d       = step_counter_q - 1'b1;
				if (step_counter_q == '0)
					state_d = S_MUL_FIX;
			end
			S_MUL_FIX:
			begin
				operand_buffer_reg_d = mul_fix[16:1];
				dest_work_reg_d      = {mul_fix[0], dest_work_reg_q[15:1]};
				gr_write_d = '{we: 1'b1, addr: src_num_q, data: mul_fix[16:1]};
				cc_d       = '{n: mul_fix[16], z: (mul_fix[16:1] == 16'h0000), v: 1'b0, c: 1'b0};
				cc_load_d  = 1'b1;
				state_d    = S_MUL_LOW;
			end
			S_MUL_LOW:
			begin
				// low half to source or one
				gr_write_d = '{we: 1'b1, addr: src_num_q | 3'h1, data: dest_work_reg_q};
				cc_d.n    = operand_buffer_reg_q[15];
				cc_d.z    = (operand_buffer_reg_q == 16'h0000) && (dest_work_reg_q == 16'h0000);
				cc_d.v    = 1'b0;
				cc_d.c    = (operand_buffer_reg_q != {16{dest_work_reg_q[15]}});
				cc_load_d = 1'b1;
				done_d    = 1'b1;
				brk_entry_d = break_request_sample_q;
				state_d     = S_IDLE;
			end
			default:
			begin
				state_d = S_IDLE;
			end
		endcase
	end

	// dispatch fields held for the whole sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_q      <= OP_ASH;
			src_num_q <= 3'h0;
			dst_num_q <= 3'h0;
		end
		else if (accept)
		begin
			op_q      <= op_t'(dispatch.op);
			src_num_q <= dispatch.src_num;
			dst_num_q <= dispatch.dst_num;
		end
	end

	// state and working registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q              <= S_IDLE;
			operand_buffer_reg_q <= 16'h0000;
			dest_work_reg_q      <= 16'h0000;
			source_work_reg_q    <= 16'h0000;
			step_counter_q       <= '0;
			shifted_q            <= 1'b0;
		end
		else
		begin
			state_q              <= state_d;
			operand_buffer_reg_q <= operand_buffer_reg_d;
			dest_work_reg_q      <= dest_work_reg_d;
			source_work_reg_q    <= source_work_reg_d;
			step_counter_q       <= step_counter_d;
			shifted_q            <= shifted_d;
		end
	end

	// multiply break request caught only in the correction state; pair shifts take break_request live in S_PAIR_END
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			break_request_sample_q <= 1'b0;
		else if (state_q == S_MUL_FIX)
			break_request_sample_q <= break_request;
	end

	// flags, register write and completion strobes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cc_q        <= '0;
			cc_load_q   <= 1'b0;
			gr_write_q  <= '0;
			done_q      <= 1'b0;
			begun_q     <= 1'b0;
			brk_entry_q <= 1'b0;
		end
		else
		begin
			cc_q        <= cc_d;
			cc_load_q   <= cc_load_d;
			gr_write_q  <= gr_write_d;
			done_q      <= done_d;
			begun_q     <= begun_d;
			brk_entry_q <= brk_entry_d;
		end
	end
endmodule : shift_multiply_sequencer

/* design/seq_pkg.sv */
// Purpose: constants and types for the shift and multiply sequencer
// Assumes: 16-bit data path, eight general registers
// Notes: register offsets are byte addresses on the apb slave
//
// Behaviour
// - shift count: low six bits, signed
// - load flags from source; zero count ends
// - count sign picks shift direction state
// - every shift cycle reloads flags, tests continuation
// - tests use old count; counter ends all ones
// - second word from destination number or one
// - zero pair count: extra state tests both
// - destination work register shifts alongside internally
// - pair end writes second word back only if a shift was done
// - multiplier sign extends into high product
// - setup loads operand, count fifteen, then clear
// - fifteen add-and-shift multiply cycles
// - multiplicand sign one: subtract multiplier correction
// - correction state writes high half, flags
// - final state writes low half to source or one
// - final flags from whole 32-bit product
// - branches use values at state start
// - sampled break request diverts to break service
package seq_pkg;
	localparam int          APB_ADDR_W   = 12;
	localparam int          STEP_W       = 6;
	localparam logic [11:0] CTRL_OFF     = 12'h000;
	localparam logic [11:0] STATUS_OFF   = 12'h004;
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic [5:0]  SC_MUL_INIT  = 6'h0F;
	localparam int          ST_STATE_LSB = 0;
	localparam int          ST_BUSY_BIT  = 4;
	localparam int          ST_CC_LSB    = 8;
	localparam int          ST_SC_LSB    = 16;

	typedef enum logic [1:0] {
		OP_ASH  = 2'b00,
		OP_PAIR = 2'b01,
		OP_MUL  = 2'b10
	} op_t;

	typedef enum logic [3:0] {
		S_IDLE      = 4'b0000,
		S_ASH_LOAD  = 4'b0001,
		S_ASH_COUNT = 4'b0010,
		S_ASH_TEST  = 4'b0011,
		S_LEFT      = 4'b0100,
		S_RIGHT     = 4'b0101,
		S_PAIR_END  = 4'b0110,
		S_MUL_SETUP = 4'b0111,
		S_MUL_CLEAR = 4'b1000,
		S_MUL_STEP  = 4'b1001,
		S_MUL_FIX   = 4'b1010,
		S_MUL_LOW   = 4'b1011
	} state_t;

	typedef struct packed {
		logic [1:0]  op;
		logic [2:0]  src_num;
		logic [2:0]  dst_num;
		logic [15:0] src_data;
		logic [15:0] dst_data;
	} dispatch_t;

	typedef struct packed {
		logic        we;
		logic [2:0]  addr;
		logic [15:0] data;
	} gr_write_t;

	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} cc_t;
endpackage : seq_pkg

/* verification/seq_checker.sv */
// Purpose: port checks for the sequencer
// Assumes: enable bit mirrored from apb writes
// Notes: helper latches the accepted dispatch
`timescale 1ns/100ps
module seq_checker #(
	parameter int ADDR_W = seq_pkg::APB_ADDR_W
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [ADDR_W-1:0]  paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pslverr,
	input wire logic               start,
	input wire seq_pkg::dispatch_t dispatch,
	input wire logic [2:0]         gr_rd_addr,
	input wire seq_pkg::gr_write_t gr_write,
	input wire logic               seq_busy,
	input wire logic               seq_done,
	input wire logic               fetch_begun,
	input wire logic               break_entry
);
	import seq_pkg::*;
	logic       en_q;
	logic [2:0] src_q;
	logic [2:0] dst_q;
	logic       acc;
	assign acc = start && !seq_busy && en_q && dispatch.op != 2'h3;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_q <= CTRL_EN_RST;
		else if (psel && penable && pwrite && paddr == ADDR_W'(CTRL_OFF))
			en_q <= pwdata[0];
	// operands latched so later cycles can refer back
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{src_q, dst_q} <= 6'h00;
		else if (acc)
			{src_q, dst_q} <= {dispatch.src_num, dispatch.dst_num};
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence mul_run;
		##1 (!seq_done) [*8] ##11 (gr_write.we && gr_write.addr == src_q)
		##1 (seq_done && gr_write.we && gr_write.addr == (src_q | 3'h1));
	endsequence
	a_mul_full_run: assert property (acc && dispatch.op == OP_MUL |-> mul_run)
		else $error("multiply timing or write order wrong");
	a_single_zero_end: assert property (acc && dispatch.op == OP_ASH && dispatch.dst_data[5:0] == 6'h00
		|-> ##1 (!gr_write.we && !seq_done) [*3] ##1 (seq_done && !gr_write.we && !fetch_begun))
		else $error("zero count single shift end wrong");
	a_pair_zero_end: assert property (acc && dispatch.op == OP_PAIR && dispatch.dst_data[5:0] == 6'h00
		|-> ##4 !seq_done ##1 (seq_done && fetch_begun))
		else $error("zero count pair shift end wrong");
	a_pair_word_addr: assert property (seq_busy |-> gr_rd_addr == (dst_q | 3'h1))
		else $error("second word address wrong");
	a_shift_write_done: assert property (acc && dispatch.op == OP_ASH && dispatch.dst_data[5:0] != 6'h00
		|-> ##[5:36] (seq_done && gr_write.we && gr_write.addr == src_q))
		else $error("shift result not written at end");
	a_done_flags_pair: assert property ((break_entry || fetch_begun) |-> seq_done)
		else $error("end flag without done");
	a_done_ends_busy: assert property (seq_done |-> !seq_busy && $past(seq_busy))
		else $error("done without a run");
	a_unmapped_error: assert property (psel && !penable && paddr != ADDR_W'(CTRL_OFF)
		&& paddr != ADDR_W'(STATUS_OFF) |=> pslverr)
		else $error("unmapped access without error");
	a_refused_start: assert property (start && !seq_busy && (!en_q || dispatch.op == 2'h3) |=> !seq_busy)
		else $error("refused start began a run");
endmodule : seq_checker
bind shift_multiply_sequencer seq_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pslverr, .start, .dispatch, .gr_rd_addr, .gr_write, .seq_busy,
	.seq_done, .fetch_begun, .break_entry);

/* verification/gr_file_model.sv */
// Purpose: general register file beside the sequencer
// Assumes: combinational read port
// Notes: bench preloads words while idle
`timescale 1ns/100ps
module gr_file_model (
	input wire logic               pclk,
	input wire logic [2:0]         rd_addr,
	output logic     [15:0]        rd_data,
	input wire seq_pkg::gr_write_t wr
);
	import seq_pkg::*;
	logic [15:0] regs [8];
	assign rd_data = regs[rd_addr];
	always @(posedge pclk)
		if (wr.we)
			regs[wr.addr] <= wr.data;
endmodule : gr_file_model

/* verification/test_shift_multiply_sequencer.sv */
// Purpose: directed tests of shifts, multiply and apb
// Assumes: operands live in the register file model
// Notes: results read back from the model
`timescale 1ns/100ps
module test_shift_multiply_sequencer;
	import seq_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        start;
	dispatch_t   dispatch;
	logic [2:0]  gr_rd_addr;
	logic [15:0] gr_rd_data;
	gr_write_t   gr_write;
	cc_t         cc;
	logic        cc_load;
	logic        break_request;
	logic        seq_busy;
	logic        seq_done;
	logic        fetch_begun;
	logic        break_entry;
	int          errors;
	int          samples_checked;
	int          cyc;
	int          k;
	int          nl;
	logic        er;
	logic        fb;
	logic        be;
	logic [2:0]  s;
	logic [31:0] rd;
	logic [31:0] e;
	logic [31:0] p;
	logic [15:0] vs [4] = '{16'h0000, 16'h2135, 16'hC135, 16'h4001};
	logic [15:0] cs [4] = '{16'hFFC0, 16'h0003, 16'h003E, 16'h0020};
	logic [15:0] ms [8] = '{16'h0003, 16'hFFFD, 16'h0003, 16'hFFFD, 16'h8000, 16'h0000, 16'h7FFF, 16'h1234};
	logic [15:0] md [8] = '{16'h0005, 16'h0005, 16'hFFFB, 16'hFFFB, 16'h8000, 16'h1234, 16'h0002, 16'hFFFF};
	shift_multiply_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .start, .dispatch, .gr_rd_addr, .gr_rd_data, .gr_write, .cc, .cc_load,
		.break_request, .seq_busy, .seq_done, .fetch_begun, .break_entry);
	gr_file_model gr (.pclk, .rd_addr(gr_rd_addr), .rd_data(gr_rd_data), .wr(gr_write));
	always #5 pclk = ~pclk;
	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", w, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic run(input logic [1:0] op, input logic [2:0] sn, dn, input logic [15:0] sd, dd);
		dispatch <= '{op, sn, dn, sd, dd};
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		cyc = 0;
		nl = 0;
		do
		begin
			@(posedge pclk);
			cyc++;
			// flag loads counted over the whole run
			if (cc_load === 1'b1)
				nl++;
		end
		while (seq_done !== 1'b1 && cyc < 100);
		fb = fetch_begun;
		be = break_entry;
		// let the last write land in the model
		@(posedge pclk);
	endtask : run
	function automatic logic [31:0] ashx(input logic [31:0] v, input logic [5:0] c);
		k = $signed(c);
		if (k < 0)
			return $signed(v) >>> (-k);
		return v << k;
	endfunction : ashx
	task automatic stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial
	begin
		#200000;
		errors++;
		stop_test();
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		start = 1'b0;
		dispatch = '0;
		break_request = 1'b0;
		errors = 0;
		samples_checked = 0;
		for (int i = 0; i < 8; i++)
			gr.regs[i] = 16'h0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, CTRL_OFF, 32'h0);
		check("ctrl reset", rd, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		check("unmapped err", er, 32'h1);
		apb(1'b1, STATUS_OFF, 32'hFFFF);
		check("status write err", er, 32'h0);
		apb(1'b0, STATUS_OFF, 32'h0);
		check("status idle", rd & 32'h1F, 32'h0);
		// disabled start, then reserved op code, both refused
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, CTRL_OFF, i);
			dispatch <= '{i ? 2'h3 : 2'h0, 3'h0, 3'h0, 16'h0001, 16'h0001};
			start <= 1'b1;
			@(posedge pclk);
			start <= 1'b0;
			repeat (2) @(posedge pclk);
			check("refused busy", seq_busy, 32'h0);
		end
		for (int i = 0; i < 4; i++)
		begin
			gr.regs[1] = vs[i];
			run(OP_ASH, 3'h1, 3'h2, vs[i], cs[i]);
			e = ashx({{16{vs[i][15]}}, vs[i]}, cs[i][5:0]);
			check("ash cycles", cyc, 4 + (k < 0 ? -k : k));
			check("ash result", gr.regs[1], e[15:0]);
			check("ash n", cc.n, e[15]);
			check("ash z", cc.z, e[15:0] == 16'h0);
			p = {{16{vs[i][15]}}, vs[i]};
			check("ash loads", nl, 1 + (k < 0 ? -k : k));
			check("ash c", cc.c, k > 0 ? p[16 - k] : (k < 0 ? p[-k - 1] : 1'b0));
			check("ash v", cc.v, k > 0 ? p[16 - k] ^ p[15 - k] : 1'b0);
			apb(1'b0, STATUS_OFF, 32'h0);
			if (k != 0)
				check("ash count end", rd[21:16], 32'h3F);
		end
		for (int i = 0; i < 3; i++)
		begin
			gr.regs[2] = 16'hAAAA;
			gr.regs[3] = i ? 16'h4003 : 16'h0001;
			gr.regs[6] = i ? 16'h8001 : 16'h0000;
			e = ashx({gr.regs[6], gr.regs[3]}, i == 2 ? 6'h3F : {i[3:0], 2'h0});
			run(OP_PAIR, 3'h6, 3'h2, gr.regs[6], i == 2 ? 16'h003F : {i[13:0], 2'h0});
			check("pair cycles", cyc, 5 + (k < 0 ? -k : k));
			check("pair fetch", fb, 32'h1);
			check("pair low", gr.regs[3], e[15:0]);
			check("pair decoy", gr.regs[2], 32'hAAAA);
			check("pair z", cc.z, e == 32'h0);
			check("pair loads", nl, 2 + (k < 0 ? -k : k));
			if (k != 0)
				check("pair high", gr.regs[6], e[31:16]);
		end
		for (int i = 0; i < 8; i++)
		begin
			s = (i == 6) ? 3'h5 : 3'h4;
			break_request <= (i == 7);
			run(OP_MUL, s, 3'h0, ms[i], md[i]);
			p = $signed(ms[i]) * $signed(md[i]);
			check("mul cycles", cyc, 32'd20);
			check("mul low", gr.regs[s | 3'h1], p[15:0]);
			if (s == 3'h4)
				check("mul high", gr.regs[4], p[31:16]);
			check("mul z", cc.z, p == 32'h0);
			check("mul c", cc.c, p != {{16{p[15]}}, p[15:0]});
			check("mul n", cc.n, p[31]);
			check("mul break", be, i == 7);
			check("mul fetch", fb, 32'h0);
			check("mul loads", nl, 32'd2);
			check("mul v", cc.v, 32'h0);
		end
		break_request <= 1'b0;
		stop_test();
	end
endmodule : test_shift_multiply_sequencer
